// ===== tx_fetch_pkg.sv
// Constants, field positions, timing counts and state type for the transmit fetch block.
// Assumes a single 100 MHz clock drives both the control and the fetch logic.
//
// Contract
// - Stopped indicator drops one cycle after go.
// - First descriptor fetch waits 4+3+z clock periods.
// - Handshake delay z is two longer periods.
// - 32-bit bus reads descriptor as three words.
// - 16-bit bus reads descriptor as six words.
// - Frame data fetched by width, pushed into FIFO.
// - One idle cycle between bus accesses; two between successive data reads.
// - Order: enter, descriptors, data, then transmit.
package tx_fetch_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;  // Block clock period
  localparam int CSR_PERIOD_NS   = 10;  // Control side clock period
  localparam int DMA_PERIOD_NS   = 10;  // Fetch side clock period
  localparam int START_DMA_PER   = 4;   // Fetch side periods in start delay
  localparam int START_CSR_PER   = 3;   // Control side periods in start delay
  localparam int HANDSHAKE_PER   = 2;   // Periods of the slower clock in z
  // Handshake delay z uses the longer of the two periods
  localparam int Z_NS = HANDSHAKE_PER *
                        ((DMA_PERIOD_NS > CSR_PERIOD_NS) ? DMA_PERIOD_NS : CSR_PERIOD_NS);
  localparam int START_DELAY_NS  = START_DMA_PER * DMA_PERIOD_NS +
                                   START_CSR_PER * CSR_PERIOD_NS + Z_NS;
  // Least time: round up, never below one cycle
  localparam int START_CYC_RAW   = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_CYC       = (START_CYC_RAW < 1) ? 1 : START_CYC_RAW;

  // ****************************************************************
  // Descriptor layout
  // ****************************************************************
  localparam int DESC_BITS       = 96;  // Three 32-bit descriptor words
  localparam int BCNT_LSB        = 32;  // Byte count field in second word
  localparam int BCNT_W          = 11;  // Byte count width
  localparam int BUFA_LSB        = 64;  // Buffer address in third word
  localparam int BUFA_W          = 32;  // Buffer address width

  // ****************************************************************
  // Bus encodings and reset values
  // ****************************************************************
  localparam logic MEM_RW_READ   = 1'b1;  // Read direction on the memory bus
  localparam logic STOPPED_RST   = 1'b1;  // Process is stopped after reset

  // Fetch sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DESC_REQ,
    ST_DESC_GAP,
    ST_DATA_REQ,
    ST_DATA_GAP
  } fetch_state_t;

endpackage

// ===== tx_stream_if.sv
// Valid/ready word stream between the fetch sequencer and its FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tx_stream_if #(
  parameter int W = 32  // Word width
);
  logic         valid;  // Word offered
  logic         ready;  // Word accepted when valid
  logic [W-1:0] data;   // Word payload

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== tx_word_fifo.sv
// Flip-flop FIFO with valid/ready on both sides, width and depth as parameters.
// Assumes DEPTH is a power of two and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tx_word_fifo #(
  parameter int W     = 32,  // Word width
  parameter int DEPTH = 8    // Number of words
) (
  input  wire logic   i_clk,      // Block clock
  input  wire logic   i_reset_n,  // Synchronous reset, active low
  tx_stream_if.snk    wr,         // Filling side
  tx_stream_if.src    rd          // Draining side
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];  // Word storage
  logic [AW:0]  wptr_q;         // Write pointer with wrap bit
  logic [AW:0]  rptr_q;         // Read pointer with wrap bit

  // ****************************************************************
  // Status decode
  // ****************************************************************
  wire empty = (wptr_q == rptr_q);
  wire full  = (wptr_q[AW-1:0] == rptr_q[AW-1:0]) && (wptr_q[AW] != rptr_q[AW]);
  wire push  = wr.valid && !full;
  wire pop   = rd.ready && !empty;

  assign wr.ready = !full;             // Back-pressure to the sequencer
  assign rd.valid = !empty;
  assign rd.data  = mem_q[rptr_q[AW-1:0]];

  // Storage write, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wptr_q[AW-1:0]] <= wr.data;
    end
  end

  // Pointer update
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tx_descriptor_fetch_start.sv
// Transmit start and descriptor/data fetch sequencer with FIFO toward the transmit RAM.
// Assumes the go bit and memory bus run on i_clk; the memory acks no sooner than two cycles.
`timescale 1ns/1ps
`default_nettype none
module tx_descriptor_fetch_start #(
  parameter int DATA_W  = 32,  // Memory bus width, 32 or 16
  parameter int ADDR_W  = 32,  // Memory address width
  parameter int TWA_W   = 9,   // Transmit RAM address width
  parameter int FIFO_D  = 8    // Words held between fetch and RAM
) (
  input  wire logic              i_clk,                  // 100 MHz clock
  input  wire logic              i_reset_n,              // Sync reset, active low
  input  wire logic              i_transmit_go_bit,      // Go bit, level
  input  wire logic [ADDR_W-1:0] i_desc_base,            // Descriptor base address
  output logic                   o_tx_stopped,           // Process stopped
  output logic                   o_mem_request,          // Bus request
  input  wire logic              i_mem_acknowledge,      // Bus acknowledge
  output logic                   o_mem_read_write,       // Bus direction
  output logic [ADDR_W-1:0]      o_mem_address,          // Bus address
  input  wire logic [DATA_W-1:0] i_mem_read_bus,         // Bus read data
  input  wire logic              i_tx_ram_ready,         // Transmit RAM can take a word
  output logic                   o_tx_fifo_write_enable, // RAM write strobe
  output logic [TWA_W-1:0]       o_tx_fifo_write_address,// RAM write address
  output logic [DATA_W-1:0]      o_tx_fifo_write_bus     // RAM write data
);
  import tx_fetch_pkg::*;

  // ****************************************************************
  // Derived sizes
  // ****************************************************************
  localparam int BYTES     = DATA_W / 8;          // Bytes per bus word
  localparam int DESC_WRDS = DESC_BITS / DATA_W;  // 3 at 32 bits, 6 at 16 bits
  localparam int CNT_W     = 12;                  // Word and delay counters
  localparam logic [CNT_W-1:0]  START_CNT = CNT_W'(START_CYC - 1);
  localparam logic [CNT_W-1:0]  DESC_LAST = CNT_W'(DESC_WRDS - 1);
  localparam logic [ADDR_W-1:0] ADDR_STEP = ADDR_W'(BYTES);

  // ****************************************************************
  // State
  // ****************************************************************
  fetch_state_t           state_q, state_d;  // Sequencer state
  logic                   go_prev_q;         // Go bit last cycle
  logic                   stopped_q;         // Stopped indicator
  logic [CNT_W-1:0]       cnt_q;             // Delay or descriptor word count
  logic [CNT_W-1:0]       words_q;           // Data words still to fetch
  logic                   req_q;             // Request held to the bus
  logic [ADDR_W-1:0]      addr_q;            // Current bus address
  logic [DESC_BITS-1:0]   desc_q;            // Assembled descriptor
  logic                   push_q;            // Word offered to FIFO
  logic [DATA_W-1:0]      push_data_q;       // Word offered to FIFO
  logic                   wen_q;             // RAM write strobe
  logic [TWA_W-1:0]       waddr_q;           // Address of current RAM write
  logic [TWA_W-1:0]       wnext_q;           // Address of next RAM write
  logic [DATA_W-1:0]      wdata_q;           // RAM write data
  logic                   rw_q;              // Bus direction

  tx_stream_if #(.W(DATA_W)) fill_if ();
  tx_stream_if #(.W(DATA_W)) drain_if ();

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire go_rise   = i_transmit_go_bit && !go_prev_q;
  wire acked     = req_q && i_mem_acknowledge;
  wire desc_done = (cnt_q == DESC_LAST);
  // Descriptor fields once assembled; the last word arrives with the ack
  wire [DESC_BITS-1:0] desc_full = {i_mem_read_bus, desc_q[DESC_BITS-1:DATA_W]};
  wire [BCNT_W-1:0]    bcnt      = desc_full[BCNT_LSB +: BCNT_W];
  wire [CNT_W-1:0]     bcnt_wide = CNT_W'(bcnt);
  // Round the byte count up to whole bus words
  wire [CNT_W-1:0]     frame_words = CNT_W'((bcnt_wide + CNT_W'(BYTES - 1)) / CNT_W'(BYTES));
  wire [ADDR_W-1:0]    buf_addr  = ADDR_W'(desc_full[BUFA_LSB +: BUFA_W]);
  // A data read may only start while the FIFO can take its word
  wire fifo_room = fill_if.ready && !push_q;
  wire drain     = drain_if.valid && i_tx_ram_ready;

  assign fill_if.valid  = push_q;
  assign fill_if.data   = push_data_q;
  assign drain_if.ready = i_tx_ram_ready;

  // Next state of the sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (go_rise) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        if (cnt_q == START_CNT) begin
          state_d = ST_DESC_REQ;
        end
      end
      ST_DESC_REQ: begin
        if (acked) begin
          if (!desc_done) begin
            state_d = ST_DESC_GAP;
          end else if (frame_words == '0) begin
            state_d = ST_IDLE;
          end else begin
            state_d = ST_DATA_GAP;
          end
        end
      end
      ST_DESC_GAP: begin
        state_d = ST_DESC_REQ;
      end
      ST_DATA_REQ: begin
        if (acked) begin
          state_d = (words_q == CNT_W'(1)) ? ST_IDLE : ST_DATA_GAP;
        end
      end
      ST_DATA_GAP: begin
        if (fifo_room) begin
          state_d = ST_DATA_REQ;
        end
      end
    endcase
  end

  // Sequencer state and go edge
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q   <= ST_IDLE;
      go_prev_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      go_prev_q <= i_transmit_go_bit;
    end
  end

  // Stopped indicator falls the cycle after the go bit is set
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      stopped_q <= STOPPED_RST;
    end else if (state_q == ST_IDLE && go_rise) begin
      stopped_q <= 1'b0;
    end else if (state_q != ST_IDLE && state_d == ST_IDLE) begin
      stopped_q <= 1'b1;                                   // Frame fully fetched
    end
  end

  // Start delay and descriptor word counter
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
    end else if (state_q == ST_IDLE || (state_q == ST_START && state_d != ST_START)) begin
      cnt_q <= '0;
    end else if (state_q == ST_START || (state_q == ST_DESC_REQ && acked)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Bus request and address
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      req_q  <= 1'b0;
      addr_q <= '0;
    end else begin
      if (acked) begin
        req_q  <= 1'b0;                                    // Drop for the idle cycle
      end else if (state_d == ST_DESC_REQ && state_q != ST_DESC_REQ) begin
        req_q  <= 1'b1;
      end else if (state_d == ST_DATA_REQ && state_q != ST_DATA_REQ) begin
        req_q  <= 1'b1;
      end
      if (state_q == ST_START) begin
        addr_q <= i_desc_base;
      end else if (state_q == ST_DESC_REQ && acked && desc_done) begin
        addr_q <= buf_addr;                                // Data buffer follows
      end else if (acked) begin
        addr_q <= addr_q + ADDR_STEP;
      end
    end
  end

  // Descriptor assembly, low word first
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      desc_q <= '0;
    end else if (state_q == ST_DESC_REQ && acked) begin
      desc_q <= desc_full;
    end
  end

  // Data words remaining in the frame
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      words_q <= '0;
    end else if (state_q == ST_DESC_REQ && acked && desc_done) begin
      words_q <= frame_words;
    end else if (state_q == ST_DATA_REQ && acked) begin
      words_q <= words_q - 1'b1;
    end
  end

  // Fetched data word offered to the FIFO until taken
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      push_q      <= 1'b0;
      push_data_q <= '0;
    end else if (state_q == ST_DATA_REQ && acked) begin
      push_q      <= 1'b1;
      push_data_q <= i_mem_read_bus;
    end else if (fill_if.ready) begin
      push_q      <= 1'b0;
    end
  end

  // ****************************************************************
  // FIFO between bus fetch and transmit RAM
  // ****************************************************************
  tx_word_fifo #(.W(DATA_W), .DEPTH(FIFO_D)) u_fifo (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .wr        (fill_if),
    .rd        (drain_if)
  );

  // Registered write port to the transmit RAM; address restarts per frame
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wen_q   <= 1'b0;
      waddr_q <= '0;
      wnext_q <= '0;
      wdata_q <= '0;
    end else begin
      wen_q <= drain;
      if (drain) begin
        waddr_q <= wnext_q;
        wdata_q <= drain_if.data;
      end
      // A new frame's restart wins over a word of the old frame leaving
      if (state_q == ST_IDLE && go_rise) begin
        wnext_q <= '0;
      end else if (drain) begin
        wnext_q <= wnext_q + 1'b1;
      end
    end
  end

  // Direction register; the block only ever reads from memory
  always_ff @(posedge i_clk) begin
    rw_q <= MEM_RW_READ;
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  assign o_tx_stopped            = stopped_q;
  assign o_mem_request           = req_q;
  assign o_mem_read_write        = rw_q;
  assign o_mem_address           = addr_q;
  assign o_tx_fifo_write_enable  = wen_q;
  assign o_tx_fifo_write_address = waddr_q;
  assign o_tx_fifo_write_bus     = wdata_q;
endmodule
`default_nettype wire

// ===== tx_fetch_mem_model.sv
// Shared memory model answering the fetch block's read requests.
// Assumes one clock; descriptor fields come from the bench.
`timescale 1ns/1ps
`default_nettype none
module tx_fetch_mem_model #(
  parameter int ADDR_W = 32,  // Address width
  parameter int DATA_W = 32   // Data width
) (
  input  wire logic              i_clk,             // Clock
  input  wire logic              i_reset_n,         // Sync reset, active low
  input  wire logic              i_mem_request,     // Read request
  input  wire logic [ADDR_W-1:0] i_mem_address,     // Read address
  input  wire logic [3:0]        i_delay,           // Ack delay, 2 or more
  input  wire logic [31:0]       i_base,            // Descriptor base
  input  wire logic [31:0]       i_count,           // Byte count field
  input  wire logic [31:0]       i_buf,             // Buffer address field
  output logic                   o_mem_acknowledge, // Ack pulse
  output logic [DATA_W-1:0]      o_mem_read_bus     // Read data
);
  // ****************************************************************
  // Memory contents
  // ****************************************************************
  logic [3:0] wait_q;  // Cycles the request has waited

  // Descriptor words at base, pattern from address elsewhere
  // Words are 32 bits wide; a 16-bit bus takes one half by address bit 1
  function automatic logic [31:0] word_at(input logic [31:0] a);
    logic [31:0] b;
    b = {a[31:2], 2'b00};
    if (b == i_base) begin
      return 32'h8000_0000;
    end
    if (b == i_base + 32'h4) begin
      return i_count;
    end
    if (b == i_base + 32'h8) begin
      return i_buf;
    end
    return {b[15:0], ~b[15:0]};
  endfunction

  // Ack no sooner than the set delay; idle data inverts every cycle
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wait_q            <= 4'h0;
      o_mem_acknowledge <= 1'b0;
      o_mem_read_bus    <= '0;
    end else if (i_mem_request && !o_mem_acknowledge) begin
      wait_q            <= wait_q + 4'h1;
      o_mem_acknowledge <= (wait_q + 4'h1 >= i_delay);
      o_mem_read_bus    <= DATA_W'(word_at(32'(i_mem_address)) >> (i_mem_address[1] ? 16 : 0));
    end else begin
      wait_q            <= 4'h0;
      o_mem_acknowledge <= 1'b0;
      o_mem_read_bus    <= ~o_mem_read_bus;
    end
  end
endmodule
`default_nettype wire

// ===== tx_descriptor_fetch_start_sva.sv
// Port checks for the transmit fetch block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tx_descriptor_fetch_start_sva #(
  parameter int DATA_W = 32,  // Bus width
  parameter int ADDR_W = 32,  // Address width
  parameter int TWA_W  = 9    // RAM address width
) (
  input wire logic              i_clk,                   // Clock
  input wire logic              i_reset_n,               // Reset, active low
  input wire logic              i_transmit_go_bit,       // Go bit
  input wire logic [ADDR_W-1:0] i_desc_base,             // Descriptor base
  input wire logic              o_tx_stopped,            // Stopped
  input wire logic              o_mem_request,           // Request
  input wire logic              i_mem_acknowledge,       // Ack
  input wire logic              o_mem_read_write,        // Direction
  input wire logic [ADDR_W-1:0] o_mem_address,           // Address
  input wire logic              i_tx_ram_ready,          // RAM ready
  input wire logic              o_tx_fifo_write_enable   // RAM write
);
  import tx_fetch_pkg::*;
  localparam int DW = DESC_BITS / DATA_W;  // Descriptor reads
  logic [3:0]        n_ack_q;   // Acks this frame, saturating
  logic [ADDR_W-1:0] last_a_q;  // Last acked address

  // Count acks from each start so order can be judged
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || $fell(o_tx_stopped)) begin
      n_ack_q <= 4'h0;
    end else if (o_mem_request && i_mem_acknowledge && n_ack_q != 4'hf) begin
      n_ack_q <= n_ack_q + 4'h1;
    end
    if (o_mem_request && i_mem_acknowledge) begin
      last_a_q <= o_mem_address;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_stop_falls: assert property ($rose(i_transmit_go_bit) && o_tx_stopped |=> !o_tx_stopped)
    else $error("stopped did not fall after go");
  a_start_delay: assert property ($fell(o_tx_stopped) |->
    (!o_mem_request)[*8] ##1 !o_mem_request ##1 o_mem_request)
    else $error("first request not nine cycles after start");
  a_req_holds: assert property (o_mem_request && !i_mem_acknowledge |=>
    o_mem_request && $stable(o_mem_address)) else $error("request dropped before ack");
  a_idle_gap: assert property (o_mem_request && i_mem_acknowledge |=> !o_mem_request)
    else $error("no idle cycle after access");
  a_first_addr: assert property ($rose(o_mem_request) && n_ack_q == 0 |->
    o_mem_address == i_desc_base) else $error("first read not at base");
  a_desc_step: assert property ($rose(o_mem_request) && n_ack_q != 0 && n_ack_q < DW |->
    o_mem_address == last_a_q + ADDR_W'(DATA_W / 8)) else $error("descriptor address step");
  a_write_late: assert property (o_tx_fifo_write_enable |-> n_ack_q > DW)
    else $error("write before descriptor done");
  a_write_cause: assert property (o_tx_fifo_write_enable |-> $past(i_tx_ram_ready))
    else $error("write without ready");
  a_busy_run: assert property (o_mem_request |-> !o_tx_stopped)
    else $error("request while stopped");
  a_read_only: assert property (o_mem_read_write == MEM_RW_READ)
    else $error("bus not reading");

  c_start: cover property ($fell(o_tx_stopped));
  c_stall: cover property (!i_tx_ram_ready && o_mem_request && i_mem_acknowledge);
  c_write: cover property (o_tx_fifo_write_enable);
endmodule

bind tx_descriptor_fetch_start tx_descriptor_fetch_start_sva #(.DATA_W(DATA_W),
  .ADDR_W(ADDR_W), .TWA_W(TWA_W)) tx_descriptor_fetch_start_sva_i (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_transmit_go_bit(i_transmit_go_bit), .i_desc_base(i_desc_base),
  .o_tx_stopped(o_tx_stopped), .o_mem_request(o_mem_request),
  .i_mem_acknowledge(i_mem_acknowledge), .o_mem_read_write(o_mem_read_write),
  .o_mem_address(o_mem_address), .i_tx_ram_ready(i_tx_ram_ready),
  .o_tx_fifo_write_enable(o_tx_fifo_write_enable));
`default_nettype wire

// ===== tx_descriptor_fetch_start_test.sv
// Self-checking bench for the transmit fetch block, 32-bit and 16-bit buses side by side.
// Assumes the memory model file and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tx_descriptor_fetch_start_test;
  localparam logic [31:0] BASE = 32'h0000_3000;  // Descriptor base
  localparam logic [31:0] BUFA = 32'h0000_5000;  // Frame buffer
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_transmit_go_bit = 1'b0, i_tx_ram_ready = 1'b1;
  logic ack, req, stp, we;           // Handshake and status
  logic [31:0] adr, rdat, wdat;      // Bus and RAM words
  logic [8:0] waddr;                 // RAM write address
  logic ack16, req16, stp16, we16;   // Same for the 16-bit block
  logic [31:0] adr16;                // 16-bit block address
  logic [15:0] rdat16, wdat16;       // 16-bit bus and RAM words
  logic [8:0] waddr16;               // 16-bit block RAM address
  logic [31:0] acks16[$], wa16[$], wd16[$];  // 16-bit traffic
  logic [31:0] count_q = 32'h0;      // Byte count in memory
  logic [3:0] delay_q = 4'h2;        // Memory ack delay
  logic [31:0] acks[$], wa[$], wd[$];  // Logged traffic
  int n_mismatch = 0, check_count = 0, cyc = 0;

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  tx_descriptor_fetch_start tx_descriptor_fetch_start_i (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_transmit_go_bit(i_transmit_go_bit), .i_desc_base(BASE),
    .o_tx_stopped(stp), .o_mem_request(req), .i_mem_acknowledge(ack),
    .o_mem_read_write(), .o_mem_address(adr), .i_mem_read_bus(rdat),
    .i_tx_ram_ready(i_tx_ram_ready), .o_tx_fifo_write_enable(we),
    .o_tx_fifo_write_address(waddr), .o_tx_fifo_write_bus(wdat));
  tx_fetch_mem_model tx_fetch_mem_model_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_mem_request(req), .i_mem_address(adr), .i_delay(delay_q), .i_base(BASE),
    .i_count(count_q), .i_buf(BUFA), .o_mem_acknowledge(ack), .o_mem_read_bus(rdat));
  tx_descriptor_fetch_start #(.DATA_W(16)) tx_descriptor_fetch_start_w16_i (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_transmit_go_bit(i_transmit_go_bit), .i_desc_base(BASE),
    .o_tx_stopped(stp16), .o_mem_request(req16), .i_mem_acknowledge(ack16),
    .o_mem_read_write(), .o_mem_address(adr16), .i_mem_read_bus(rdat16),
    .i_tx_ram_ready(i_tx_ram_ready), .o_tx_fifo_write_enable(we16),
    .o_tx_fifo_write_address(waddr16), .o_tx_fifo_write_bus(wdat16));
  tx_fetch_mem_model #(.DATA_W(16)) tx_fetch_mem_model_w16_i (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_mem_request(req16), .i_mem_address(adr16),
    .i_delay(delay_q), .i_base(BASE), .i_count(count_q), .i_buf(BUFA),
    .o_mem_acknowledge(ack16), .o_mem_read_bus(rdat16));

  // Log accepted reads and RAM writes; hang guard ends the run
  always @(posedge i_clk) begin
    if (req && ack) acks.push_back(adr);
    if (we) begin
      wa.push_back(32'(waddr));
      wd.push_back(wdat);
    end
    if (req16 && ack16) acks16.push_back(adr16);
    if (we16) begin
      wa16.push_back(32'(waddr16));
      wd16.push_back(32'(wdat16));
    end
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One frame: start delay, reads, optional stall or ignored go, RAM words
  task automatic run_frame(input logic [31:0] nb, input logic [3:0] dly,
                           input logic stall, input logic again);
    int k;
    int n;
    int n16;
    logic [31:0] nw;
    logic [31:0] nh;
    logic [15:0] h;
    nw = (nb + 32'h3) >> 2;
    nh = (nb + 32'h1) >> 1;
    acks.delete();
    wa.delete();
    wd.delete();
    acks16.delete();
    wa16.delete();
    wd16.delete();
    @(posedge i_clk);
    check(32'(stp), 32'h1);
    check(32'(stp16), 32'h1);
    count_q <= nb;
    delay_q <= dly;
    i_tx_ram_ready <= !stall;
    i_transmit_go_bit <= 1'b1;
    @(posedge i_clk);
    #1 check(32'(stp), 32'h0);
    check(32'(stp16), 32'h0);
    k = 0;
    while (req !== 1'b1 && k < 50) begin
      @(posedge i_clk);
      i_transmit_go_bit <= 1'b0;
      #1 k++;
    end
    check(32'(k), 32'd9);
    check(32'(req16), 32'h1);
    if (again) begin
      @(posedge i_clk);
      i_transmit_go_bit <= 1'b1;
      @(posedge i_clk);
      i_transmit_go_bit <= 1'b0;
    end
    if (stall) begin
      repeat (200) @(posedge i_clk);
      #1 n = acks.size();
      n16 = acks16.size();
      repeat (20) @(posedge i_clk);
      #1 check(32'(acks.size()), 32'(n));
      check(32'(acks16.size()), 32'(n16));
      check(32'(n < 3 + nw), 32'h1);
      check(32'(n16 < 6 + nh), 32'h1);
      @(posedge i_clk);
      i_tx_ram_ready <= 1'b1;
    end
    k = 0;
    while ((stp & stp16) !== 1'b1 && k < 3000) begin
      @(posedge i_clk);
      #1 k++;
    end
    repeat (20) @(posedge i_clk);
    #1 check(32'(acks.size()), 32'h3 + nw);
    foreach (acks[i]) check(acks[i], (i < 3) ? BASE + 32'(4 * i) : BUFA + 32'(4 * (i - 3)));
    check(32'(wa.size()), nw);
    foreach (wa[i]) check(wa[i], 32'(i));
    foreach (wd[i]) check(wd[i], {BUFA[15:0] + 16'(4 * i), ~(BUFA[15:0] + 16'(4 * i))});
    check(32'(acks16.size()), 32'h6 + nh);
    foreach (acks16[i]) check(acks16[i], (i < 6) ? BASE + 32'(2 * i) : BUFA + 32'(2 * (i - 6)));
    check(32'(wa16.size()), nh);
    foreach (wa16[i]) check(wa16[i], 32'(i));
    foreach (wd16[i]) begin
      h = BUFA[15:0] + 16'(4 * (i / 2));
      if (i % 2 == 0) h = ~h;
      check(wd16[i], 32'(h));
    end
    $display("frame of %0d bytes done, checks=%0d", nb, check_count);
  endtask

  initial begin
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    run_frame(32'd12, 4'h2, 1'b0, 1'b0);
    run_frame(32'd0, 4'h3, 1'b0, 1'b1);
    run_frame(32'd48, 4'h5, 1'b1, 1'b0);
    run_frame(32'd6, 4'h2, 1'b0, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
